// ### src/ealu_defines.vh
// Constants for the 8-bit execution datapath: opcodes, flag positions, cycle counts.
// Assumes the decoder drives opcode codes below on the operation port.
`ifndef EALU_DEFINES_VH
`define EALU_DEFINES_VH
// Operation codes
`define EALU_OP_ADD 5'h00
`define EALU_OP_ADC 5'h01
`define EALU_OP_WORD_ADD_IMMEDIATE 5'h02
`define EALU_OP_SUB 5'h03
`define EALU_OP_SBC 5'h04
`define EALU_OP_WORD_SUBTRACT_IMMEDIATE 5'h05
`define EALU_OP_AND 5'h06
`define EALU_OP_OR 5'h07
`define EALU_OP_EOR 5'h08
`define EALU_OP_COM 5'h09
`define EALU_OP_NEG 5'h0a
`define EALU_OP_CLRB 5'h0b
`define EALU_OP_INC 5'h0c
`define EALU_OP_DEC 5'h0d
`define EALU_OP_TST 5'h0e
`define EALU_OP_CLR 5'h0f
`define EALU_OP_SER 5'h10
`define EALU_OP_MUL 5'h11
`define EALU_OP_MULS 5'h12
`define EALU_OP_MIXED_SIGN_MULTIPLY 5'h13
`define EALU_OP_FMUL 5'h14
`define EALU_OP_FMULS 5'h15
`define EALU_OP_FRACTIONAL_MIXED_MULTIPLY 5'h16
`define EALU_OP_INDIRECT_JUMP 5'h17
`define EALU_OP_INDIRECT_SUBROUTINE_CALL 5'h18
// Flag bit positions in the status byte
`define EALU_FLG_C 0
`define EALU_FLG_Z 1
`define EALU_FLG_N 2
`define EALU_FLG_V 3
`define EALU_FLG_S 4
`define EALU_FLG_H 5
// Cycle counts
`define EALU_CYC_WORD 2'h2
`define EALU_CYC_MUL 2'h2
`define EALU_CYC_CALL 2'h3
`define EALU_STATUS_RST 8'h00
`define EALU_ALL_ONES 8'hff
`endif

// ### src/ealu_flag_reg.v
// Status flag register with per-bit write enables.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "ealu_defines.vh"
module ealu_flag_reg (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Update
  input wire [7:0] flagMask,
  input wire [7:0] flagNew,
  // State
  output wire [7:0] flags
);
  reg [7:0] flags_ff;
  genvar i;
  assign flags = flags_ff;
  // Only masked bits change
  generate
    for (i = 0; i < 8; i = i + 1) begin : gBit
      always @(posedge core_clk) begin
        if (reset)
          flags_ff[i] <= 1'b0;
        else if (flagMask[i])
          flags_ff[i] <= flagNew[i];
      end
    end
  endgenerate
endmodule // ealu_flag_reg

// ### src/ealu_datapath.v
// Execution datapath: byte/word arithmetic, logic, multiplies, indirect jumps.
// Assumes the decoder holds opcode and operands steady until opDone, and
// that the register file writes back dstValue/productValue/pairValue.
//
// Behaviour
// (RL1) Add with carry, five flags, one cycle
// (RL2) Word add immediate, five flags, two cycles
// (RL3) Subtract constant, five flags, one cycle
// (RL4) Subtract register with borrow, one cycle
// (RL5) Subtract constant with borrow, one cycle
// (RL6) Word subtract immediate, two cycles
// (RL7) AND register or constant, Z N V
// (RL8) OR register or constant, Z N V
// (RL9) Masked bit set ORs mask in
// (RL10) Masked bit clear ANDs inverted mask
// (RL11) Test ANDs register with itself, unchanged
// (RL12) Multiplies into product pair, Z C, two
// (RL13) Fractional multiplies shift product left one
// (RL14) Indirect jump loads PC from pointer
// (RL15) Indirect call loads PC, three cycles
// (RL16) Unlisted flags keep their value
// (RL17) Other byte ops write result, one cycle
`timescale 1ns/100ps
`include "ealu_defines.vh"
module ealu_datapath (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Request from decoder
  input wire opStart,
  input wire [4:0] opCode,
  input wire [7:0] dstOperand,
  input wire [7:0] srcOperand,
  input wire [15:0] pairOperand,
  input wire [15:0] pointerPair,
  // Results
  output wire opBusy,
  output reg opDone,
  output reg [7:0] dstValue,
  output reg dstWrite,
  output reg [15:0] pairValue,
  output reg pairWrite,
  output reg [15:0] productValue,
  output reg productWrite,
  output reg [15:0] pcValue,
  output reg pcLoad,
  output reg callPush,
  output wire [7:0] statusFlags
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;
  reg state_ff;
  reg nxt_state;
  reg [1:0] cnt_ff;
  reg [1:0] nxt_cnt;
  reg [4:0] op_ff;
  reg [7:0] resB;
  reg [15:0] resW;
  reg [15:0] prod;
  reg [7:0] fNew;
  reg [7:0] fMask;
  reg writeB;
  reg [1:0] cycles;
  reg [8:0] sum9;
  reg [4:0] half;
  reg [16:0] sum17;
  reg signed [17:0] mulS;
  reg carryIn;
  wire [7:0] flags;
  wire flagLoad;

  assign opBusy = (state_ff == ST_WAIT);
  assign flagLoad = opStart && !opBusy;

  // Flag storage, only masked bits updated [RL16]
  ealu_flag_reg uFlags (
    .core_clk(core_clk),
    .reset(reset),
    .flagMask(flagLoad ? fMask : 8'h00),
    .flagNew(fNew),
    .flags(flags)
  );
  assign statusFlags = flags;

  // Combinational operation decode and compute
  always @* begin
    resB = 8'h00;
    resW = 16'h0000;
    prod = 16'h0000;
    fNew = 8'h00;
    fMask = 8'h00;
    writeB = 1'b0;
    cycles = 2'h1;
    sum9 = 9'h000;
    half = 5'h00;
    sum17 = 17'h00000;
    mulS = 18'sh00000;
    carryIn = flags[`EALU_FLG_C];
    case (opCode)
      `EALU_OP_ADD, `EALU_OP_ADC: begin
        // Carry only on the with-carry form [RL1]
        if (opCode == `EALU_OP_ADD)
          carryIn = 1'b0;
        sum9 = {1'b0, dstOperand} + {1'b0, srcOperand} + {8'h00, carryIn};
        half = {1'b0, dstOperand[3:0]} + {1'b0, srcOperand[3:0]} + {4'h0, carryIn};
        resB = sum9[7:0];
        writeB = 1'b1;
        fMask = 8'h2f;
        fNew[`EALU_FLG_C] = sum9[8]; // [RL1]
        fNew[`EALU_FLG_H] = half[4];
        fNew[`EALU_FLG_V] = (dstOperand[7] == srcOperand[7]) && (resB[7] != dstOperand[7]);
      end
      `EALU_OP_SUB, `EALU_OP_SBC, `EALU_OP_NEG: begin
        // Register or constant subtrahend on srcOperand [RL3] [RL4] [RL5]
        if (opCode != `EALU_OP_SBC)
          carryIn = 1'b0;
        if (opCode == `EALU_OP_NEG) begin
          sum9 = 9'h000 - {1'b0, dstOperand};
          half = 5'h00 - {1'b0, dstOperand[3:0]};
          resB = sum9[7:0];
          fNew[`EALU_FLG_V] = (resB == 8'h80);
        end else begin
          sum9 = {1'b0, dstOperand} - {1'b0, srcOperand} - {8'h00, carryIn};
          half = {1'b0, dstOperand[3:0]} - {1'b0, srcOperand[3:0]} - {4'h0, carryIn};
          resB = sum9[7:0];
          fNew[`EALU_FLG_V] = (dstOperand[7] != srcOperand[7]) && (resB[7] != dstOperand[7]);
        end
        writeB = 1'b1;
        fMask = 8'h2f;
        fNew[`EALU_FLG_C] = sum9[8];
        fNew[`EALU_FLG_H] = half[4];
      end
      `EALU_OP_WORD_ADD_IMMEDIATE, `EALU_OP_WORD_SUBTRACT_IMMEDIATE: begin
        // Word op on the pair, result after two cycles [RL2] [RL6]
        if (opCode == `EALU_OP_WORD_ADD_IMMEDIATE)
          sum17 = {1'b0, pairOperand} + {9'h000, srcOperand};
        else
          sum17 = {1'b0, pairOperand} - {9'h000, srcOperand};
        resW = sum17[15:0];
        cycles = `EALU_CYC_WORD;
        fMask = 8'h1f;
        fNew[`EALU_FLG_C] = sum17[16];
        fNew[`EALU_FLG_Z] = (resW == 16'h0000);
        fNew[`EALU_FLG_N] = resW[15];
        if (opCode == `EALU_OP_WORD_ADD_IMMEDIATE)
          fNew[`EALU_FLG_V] = !pairOperand[15] && resW[15];
        else
          fNew[`EALU_FLG_V] = pairOperand[15] && !resW[15];
        fNew[`EALU_FLG_S] = fNew[`EALU_FLG_N] ^ fNew[`EALU_FLG_V];
      end
      `EALU_OP_AND, `EALU_OP_OR, `EALU_OP_EOR, `EALU_OP_CLRB, `EALU_OP_TST,
      `EALU_OP_CLR, `EALU_OP_INC, `EALU_OP_DEC, `EALU_OP_COM: begin
        // Logic and unary ops: Z N V (COM also sets C), V cleared for pure logic
        case (opCode)
          `EALU_OP_AND: resB = dstOperand & srcOperand; // [RL7] [RL9 shares OR]
          `EALU_OP_OR: resB = dstOperand | srcOperand; // [RL8] [RL9]
          `EALU_OP_EOR: resB = dstOperand ^ srcOperand; // [RL17]
          `EALU_OP_CLRB: resB = dstOperand & (`EALU_ALL_ONES - srcOperand); // [RL10]
          `EALU_OP_TST: resB = dstOperand & dstOperand; // [RL11]
          `EALU_OP_CLR: resB = 8'h00; // [RL17]
          `EALU_OP_INC: resB = dstOperand + 8'h01; // [RL17]
          `EALU_OP_DEC: resB = dstOperand - 8'h01; // [RL17]
          default: resB = `EALU_ALL_ONES - dstOperand; // [RL17]
        endcase
        writeB = (opCode != `EALU_OP_TST); // [RL11]
        fMask = (opCode == `EALU_OP_COM) ? 8'h0f : 8'h0e;
        fNew[`EALU_FLG_C] = 1'b1;
        if (opCode == `EALU_OP_INC)
          fNew[`EALU_FLG_V] = (dstOperand == 8'h7f);
        else if (opCode == `EALU_OP_DEC)
          fNew[`EALU_FLG_V] = (dstOperand == 8'h80);
      end
      `EALU_OP_SER: begin
        resB = `EALU_ALL_ONES; // [RL17]
        writeB = 1'b1;
      end
      `EALU_OP_MUL, `EALU_OP_MULS, `EALU_OP_MIXED_SIGN_MULTIPLY,
      `EALU_OP_FMUL, `EALU_OP_FMULS, `EALU_OP_FRACTIONAL_MIXED_MULTIPLY: begin
        // Signedness selected per operand [RL12]
        case (opCode)
          `EALU_OP_MUL, `EALU_OP_FMUL:
            mulS = $signed({1'b0, dstOperand}) * $signed({1'b0, srcOperand});
          `EALU_OP_MULS, `EALU_OP_FMULS:
            mulS = $signed({dstOperand[7], dstOperand}) * $signed({srcOperand[7], srcOperand});
          default:
            mulS = $signed({dstOperand[7], dstOperand}) * $signed({1'b0, srcOperand});
        endcase
        fMask = 8'h03;
        fNew[`EALU_FLG_C] = mulS[15];
        if (opCode == `EALU_OP_FMUL || opCode == `EALU_OP_FMULS || opCode == `EALU_OP_FRACTIONAL_MIXED_MULTIPLY)
          prod = {mulS[14:0], 1'b0}; // [RL13]
        else
          prod = mulS[15:0]; // [RL12]
        cycles = `EALU_CYC_MUL;
      end
      `EALU_OP_INDIRECT_JUMP: cycles = `EALU_CYC_WORD; // [RL14]
      `EALU_OP_INDIRECT_SUBROUTINE_CALL: cycles = `EALU_CYC_CALL; // [RL15]
      default: cycles = 2'h1;
    endcase
    if (fMask != 8'h03 && !(fMask[`EALU_FLG_S]))
      fNew[`EALU_FLG_Z] = (resB == 8'h00);
    else if (fMask == 8'h03)
      fNew[`EALU_FLG_Z] = (prod == 16'h0000);
    if (fMask[`EALU_FLG_N] && !fMask[`EALU_FLG_S])
      fNew[`EALU_FLG_N] = resB[7];
  end

  // Sequencer: count remaining cycles of multi-cycle ops
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        if (flagLoad && cycles != 2'h1) begin
          nxt_state = ST_WAIT;
          nxt_cnt = cycles - 2'h1; // [RL2] [RL15]
        end
      end
      ST_WAIT: begin
        nxt_cnt = cnt_ff - 2'h1;
        if (cnt_ff == 2'h1)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Registered results, captured when the request is accepted; write strobes pulse at completion
  always @(posedge core_clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 2'h0;
      op_ff <= 5'h00;
      opDone <= 1'b0;
      dstValue <= 8'h00;
      dstWrite <= 1'b0;
      pairValue <= 16'h0000;
      pairWrite <= 1'b0;
      productValue <= 16'h0000;
      productWrite <= 1'b0;
      pcValue <= 16'h0000;
      pcLoad <= 1'b0;
      callPush <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      opDone <= 1'b0;
      dstWrite <= 1'b0;
      pairWrite <= 1'b0;
      productWrite <= 1'b0;
      pcLoad <= 1'b0;
      callPush <= 1'b0;
      if (flagLoad) begin
        op_ff <= opCode;
        dstValue <= resB;
        pairValue <= resW;
        productValue <= prod;
        pcValue <= pointerPair; // [RL14] [RL15]
        if (cycles == 2'h1) begin
          opDone <= 1'b1;
          dstWrite <= writeB; // [RL17]
        end
      end else if (opBusy && cnt_ff == 2'h1) begin
        opDone <= 1'b1;
        pairWrite <= (op_ff == `EALU_OP_WORD_ADD_IMMEDIATE) || (op_ff == `EALU_OP_WORD_SUBTRACT_IMMEDIATE);
        productWrite <= (op_ff >= `EALU_OP_MUL) && (op_ff <= `EALU_OP_FRACTIONAL_MIXED_MULTIPLY);
        pcLoad <= (op_ff == `EALU_OP_INDIRECT_JUMP) || (op_ff == `EALU_OP_INDIRECT_SUBROUTINE_CALL);
        callPush <= (op_ff == `EALU_OP_INDIRECT_SUBROUTINE_CALL);
      end
    end
  end
endmodule // ealu_datapath

// ### sim/ealu_datapath_assertions.sv
// Checker for the execution datapath: latencies, write-back strobes, flags.
// Assumes it is bound to every ealu_datapath instance.
`timescale 1ns/100ps
`include "ealu_defines.vh"
module ealu_datapath_checker (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Request
  input wire opStart,
  input wire [4:0] opCode,
  input wire [7:0] dstOperand,
  input wire [7:0] srcOperand,
  input wire [15:0] pointerPair,
  // Results
  input wire opBusy,
  input wire opDone,
  input wire [7:0] dstValue,
  input wire dstWrite,
  input wire pairWrite,
  input wire productWrite,
  input wire [15:0] pcValue,
  input wire pcLoad,
  input wire callPush,
  input wire [7:0] statusFlags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Accepted request and its class
  wire take = opStart && !opBusy;
  wire isWord = opCode == `EALU_OP_WORD_ADD_IMMEDIATE || opCode == `EALU_OP_WORD_SUBTRACT_IMMEDIATE;
  wire isMul = opCode >= `EALU_OP_MUL && opCode <= `EALU_OP_FRACTIONAL_MIXED_MULTIPLY;
  wire isByte = opCode <= `EALU_OP_SER && !isWord;
  wire isLogic = opCode == `EALU_OP_AND || opCode == `EALU_OP_OR;
  wire isJump = opCode == `EALU_OP_INDIRECT_JUMP || opCode == `EALU_OP_INDIRECT_SUBROUTINE_CALL;
  wire carryNow = statusFlags[`EALU_FLG_C];
  wire [7:0] adcSum = dstOperand + srcOperand + {7'h00, carryNow};
  AST_BYTE_ONE: assert property (take && isByte |=> opDone && !opBusy)
    else $error("byte op did not finish in one cycle");
  AST_WORD_TWO: assert property (take && isWord |=> opBusy && !opDone ##1 opDone && pairWrite)
    else $error("word op did not finish in two cycles");
  AST_MUL_TWO: assert property (take && isMul |=> !opDone ##1 opDone && productWrite)
    else $error("multiply did not finish in two cycles");
  AST_CALL_THREE: assert property (take && opCode == `EALU_OP_INDIRECT_SUBROUTINE_CALL |=> opBusy [*2] ##1
    opDone && pcLoad && callPush && pcValue == $past(pointerPair, 3))
    else $error("indirect call wrong");
  AST_JUMP_PC: assert property (take && opCode == `EALU_OP_INDIRECT_JUMP |=> ##1
    pcLoad && !callPush && pcValue == $past(pointerPair, 2))
    else $error("indirect jump wrong");
  AST_JUMP_FLAGS: assert property (take && isJump |=> $stable(statusFlags))
    else $error("jump changed flags");
  AST_ADC_SUM: assert property (take && opCode == `EALU_OP_ADC |=> dstWrite && dstValue == $past(adcSum))
    else $error("add with carry result wrong");
  AST_TEST_KEEP: assert property (take && opCode == `EALU_OP_TST |=> opDone && !dstWrite)
    else $error("test wrote the register");
  AST_LOGIC_FLAGS: assert property (take && isLogic |=> !statusFlags[`EALU_FLG_V] &&
    statusFlags[`EALU_FLG_Z] == (dstValue == 8'h00) && statusFlags[`EALU_FLG_N] == dstValue[7]
    && carryNow == $past(carryNow))
    else $error("logic flags wrong");
  // Main scenarios reached
  cover property (take && opCode == `EALU_OP_INDIRECT_SUBROUTINE_CALL);
  cover property (take && isMul);
  cover property (take && isWord);
endmodule // ealu_datapath_checker

bind ealu_datapath ealu_datapath_checker ealu_datapath_checker_i (.core_clk(core_clk),
  .reset(reset), .opStart(opStart), .opCode(opCode), .dstOperand(dstOperand),
  .srcOperand(srcOperand), .pointerPair(pointerPair), .opBusy(opBusy), .opDone(opDone),
  .dstValue(dstValue), .dstWrite(dstWrite), .pairWrite(pairWrite),
  .productWrite(productWrite), .pcValue(pcValue), .pcLoad(pcLoad), .callPush(callPush),
  .statusFlags(statusFlags));

// ### sim/ealu_regfile_model.sv
// Register file stand-in: keeps the byte result and PC that the datapath writes back.
// Assumes write strobes are one-cycle pulses on core_clk.
`timescale 1ns/100ps
module ealu_regfile_model (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Write-back strobes
  input wire dstWrite,
  input wire [7:0] dstValue,
  input wire pcLoad,
  input wire [15:0] pcValue,
  // Stored contents
  output reg [7:0] dstReg_ff,
  output reg [15:0] progCnt_ff
);
  // Capture write-backs
  always @(posedge core_clk) begin
    if (reset) begin
      dstReg_ff <= 8'h00;
      progCnt_ff <= 16'h0000;
    end else begin
      if (dstWrite) dstReg_ff <= dstValue;
      if (pcLoad) progCnt_ff <= pcValue;
    end
  end
endmodule // ealu_regfile_model

// ### sim/tb_top.sv
// Self-checking bench for the execution datapath.
// Assumes a 40 MHz core clock and the opcodes of the shared header.
`timescale 1ns/100ps
`include "ealu_defines.vh"
module tb_top;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg opStart = 1'b0;
  reg [4:0] opCode = 5'h00;
  reg [7:0] dstOperand = 8'h00;
  reg [7:0] srcOperand = 8'h00;
  reg [15:0] pairOperand = 16'h0000;
  reg [15:0] pointerPair = 16'h0000;
  wire opBusy, opDone, dstWrite, pairWrite, productWrite, pcLoad, callPush;
  wire [7:0] dstValue, statusFlags, dstReg;
  wire [15:0] pairValue, productValue, pcValue, progCnt;
  integer errorCnt = 0;
  integer testsRun = 0;
  integer cyc;
  integer i;
  localparam logic [12:0] PLAIN [0:8] = '{{`EALU_OP_ADD, 8'h44}, {`EALU_OP_SUB, 8'h26},
    {`EALU_OP_EOR, 8'h3a}, {`EALU_OP_COM, 8'hca}, {`EALU_OP_NEG, 8'hcb},
    {`EALU_OP_INC, 8'h36}, {`EALU_OP_DEC, 8'h34}, {`EALU_OP_CLR, 8'h00}, {`EALU_OP_SER, 8'hff}};
  // Carry is bit 15 of the product before the fractional shift
  localparam logic [37:0] MULT [0:6] = '{{`EALU_OP_MUL, 16'hffff, 16'hfe01, 1'b1},
    {`EALU_OP_MULS, 16'hffff, 16'h0001, 1'b0}, {`EALU_OP_MIXED_SIGN_MULTIPLY, 16'hff02, 16'hfffe, 1'b1},
    {`EALU_OP_FMUL, 16'h8080, 16'h8000, 1'b0}, {`EALU_OP_FMULS, 16'hc040, 16'he000, 1'b1},
    {`EALU_OP_FRACTIONAL_MIXED_MULTIPLY, 16'h8002, 16'hfe00, 1'b1}, {`EALU_OP_MUL, 16'h5500, 16'h0000, 1'b0}};
  always #12.5 core_clk = ~core_clk;
  ealu_datapath ealu_datapath_i (.core_clk(core_clk), .reset(reset), .opStart(opStart),
    .opCode(opCode), .dstOperand(dstOperand), .srcOperand(srcOperand),
    .pairOperand(pairOperand), .pointerPair(pointerPair), .opBusy(opBusy), .opDone(opDone),
    .dstValue(dstValue), .dstWrite(dstWrite), .pairValue(pairValue), .pairWrite(pairWrite),
    .productValue(productValue), .productWrite(productWrite), .pcValue(pcValue),
    .pcLoad(pcLoad), .callPush(callPush), .statusFlags(statusFlags));
  ealu_regfile_model ealu_regfile_model_i (.core_clk(core_clk), .reset(reset),
    .dstWrite(dstWrite), .dstValue(dstValue), .pcLoad(pcLoad), .pcValue(pcValue),
    .dstReg_ff(dstReg), .progCnt_ff(progCnt));
  // Compare and count
  task chk(input string nm, input [15:0] e, input [15:0] g);
    testsRun = testsRun + 1;
    if (g !== e) begin
      errorCnt = errorCnt + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task fchk(input [7:0] e);
    chk("flags", {8'h00, e}, {8'h00, statusFlags});
  endtask
  // One request; returns after completion with its latency in cyc
  task issue(input [4:0] op, input [7:0] d, input [7:0] s, input [15:0] p);
    @(posedge core_clk) #1;
    opStart = 1'b1;
    opCode = op;
    dstOperand = d;
    srcOperand = s;
    pairOperand = p;
    @(posedge core_clk) #1;
    opStart = 1'b0;
    cyc = 1;
    while (opDone !== 1'b1 && cyc < 8) begin
      @(posedge core_clk) #1;
      cyc = cyc + 1;
    end
  endtask
  // Remaining byte ops, one cycle each
  task t_plain;
    for (i = 0; i < 9; i = i + 1) begin
      issue(PLAIN[i][12:8], 8'h35, 8'h0f, 16'h0000);
      chk("plain result", {8'h00, PLAIN[i][7:0]}, {8'h00, dstValue});
      chk("plain cycles", 16'd1, cyc[15:0]);
      chk("plain write", 16'h0001, {15'h0, dstWrite});
    end
  endtask
  // Add, add with carry, subtracts with and without borrow
  task t_arith;
    issue(`EALU_OP_ADD, 8'hff, 8'h01, 16'h0000);
    fchk(8'h23);
    issue(`EALU_OP_ADC, 8'h7f, 8'h00, 16'h0000);
    chk("adc", 16'h0080, {8'h00, dstValue});
    fchk(8'h2c);
    issue(`EALU_OP_SUB, 8'h10, 8'h20, 16'h0000);
    fchk(8'h05);
    issue(`EALU_OP_SBC, 8'h10, 8'h0e, 16'h0000);
    chk("sbc", 16'h0001, {8'h00, dstValue});
    fchk(8'h20);
  endtask
  // Word add and subtract immediate
  task t_word;
    issue(`EALU_OP_WORD_ADD_IMMEDIATE, 8'h00, 8'h01, 16'h7fff);
    chk("word add", 16'h8000, pairValue);
    fchk(8'h2c);
    chk("word cycles", 16'd2, cyc[15:0]);
    chk("pair strobe", 16'h0001, {15'h0, pairWrite});
    issue(`EALU_OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h01, 16'h0000);
    chk("word sub", 16'hffff, pairValue);
    fchk(8'h35);
  endtask
  // Logic, mask set and clear, test
  task t_logic;
    issue(`EALU_OP_AND, 8'hf0, 8'h0f, 16'h0000);
    fchk(8'h33);
    issue(`EALU_OP_OR, 8'h80, 8'h01, 16'h0000);
    chk("or", 16'h0081, {8'h00, dstValue});
    issue(`EALU_OP_CLRB, 8'hff, 8'h0f, 16'h0000);
    chk("mask clear", 16'h00f0, {8'h00, dstValue});
    fchk(8'h35);
    issue(`EALU_OP_TST, 8'h00, 8'h00, 16'h0000);
    fchk(8'h33);
    @(posedge core_clk) #1;
    chk("test keeps", 16'h00f0, {8'h00, dstReg});
  endtask
  // All six multiplies
  task t_mul;
    for (i = 0; i < 7; i = i + 1) begin
      issue(MULT[i][37:33], MULT[i][32:25], MULT[i][24:17], 16'h0000);
      chk("product", MULT[i][16:1], productValue);
      chk("product strobe", 16'h0001, {15'h0, productWrite});
      chk("mul cycles", 16'd2, cyc[15:0]);
      chk("mul carry", {15'h0, MULT[i][0]}, {15'h0, statusFlags[0]});
      chk("mul zero", {15'h0, MULT[i][16:1] == 16'h0000}, {15'h0, statusFlags[1]});
    end
  endtask
  // Indirect jump and call leave flags alone
  task t_jump;
    issue(`EALU_OP_ADD, 8'h01, 8'h01, 16'h0000);
    // Pointer differs from the word pair, so a wrong source shows
    pointerPair = 16'h1234;
    issue(`EALU_OP_INDIRECT_JUMP, 8'h00, 8'h00, 16'h5a5a);
    chk("jump pc", 16'h1234, pcValue);
    chk("jump strobes", 16'h0002, {14'h0, pcLoad, callPush});
    fchk(8'h10);
    pointerPair = 16'hbeef;
    issue(`EALU_OP_INDIRECT_SUBROUTINE_CALL, 8'h00, 8'h00, 16'h5a5a);
    chk("call cycles", 16'd3, cyc[15:0]);
    chk("call strobes", 16'h0003, {14'h0, pcLoad, callPush});
    fchk(8'h10);
    @(posedge core_clk) #1;
    chk("call pc", 16'hbeef, progCnt);
  endtask
  task endOfTest;
    $display("errors %0d checks %0d", errorCnt, testsRun);
    if (errorCnt == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    t_plain;
    t_arith;
    t_word;
    t_logic;
    t_mul;
    t_jump;
    endOfTest;
  end
  // Watchdog
  initial begin
    #(25 * 600);
    errorCnt = errorCnt + 1;
    endOfTest;
  end
endmodule // tb_top
